// >>> inc/swap_sub_pkg.sv
// Package: opcodes, field positions, phase codes and address constants for the swap/subtract datapath
package swap_sub_pkg;
   localparam int INSTR_W = 16;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 12;
   localparam int OPC_HI = 15;
   localparam int OPC_LO = 10;
   localparam int DEST_BIT = 9;
   localparam int BANK_BIT = 8;
   localparam logic [5:0] OPC_SWAP = 6'h0e;
   localparam logic [5:0] OPC_SUBB = 6'h16;
   localparam logic [7:0] INDEXED_MAX = 8'h5f;
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam int FLAG_C = 0;
   localparam int FLAG_DC = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_OV = 3;
   localparam int FLAG_N = 4;
   localparam logic [4:0] RESET_FLAGS = 5'h00;

   typedef enum logic [3:0] {
      PH_DECODE = 4'h1,
      PH_READ = 4'h2,
      PH_PROC = 4'h4,
      PH_WRITE = 4'h8
   } phase_e;
endpackage : swap_sub_pkg

// >>> inc/alu_if.sv
// Interface: operands and results between the sequencer and the arithmetic unit
`timescale 1ns/1ns
`default_nettype none
interface alu_if;
   logic [7:0] f_val;
   logic [7:0] w_val;
   logic carry_in;
   logic is_sub;
   logic [7:0] result;
   logic [4:0] flags_out;
   logic flags_we;
   modport seq (output f_val, output w_val, output carry_in, output is_sub, input result, input flags_out,
      input flags_we);
   modport alu (input f_val, input w_val, input carry_in, input is_sub, output result, output flags_out,
      output flags_we);
endinterface : alu_if
`default_nettype wire

// >>> rtl/swap_sub_alu.sv
// Combinational unit: nibble exchange and subtract with borrow with flag generation
`timescale 1ns/1ns
`default_nettype none
module swap_sub_alu (
   alu_if.alu bus
);
   wire logic [8:0] diff;
   wire logic [4:0] low_diff;
   wire logic [7:0] swapped;
   wire logic ov;

   // Borrow in is the inverted carry
   assign diff = {1'b0, bus.f_val} - {1'b0, bus.w_val} - {8'h00, ~bus.carry_in};
   assign low_diff = {1'b0, bus.f_val[3:0]} - {1'b0, bus.w_val[3:0]} - {4'h0, ~bus.carry_in};
   assign ov = (bus.f_val[7] ^ bus.w_val[7]) & (bus.f_val[7] ^ diff[7]);
   assign swapped = {bus.f_val[3:0], bus.f_val[7:4]};
   assign bus.result = bus.is_sub ? diff[7:0] : swapped;
   // Carry and digit carry are active high when no borrow occurs
   assign bus.flags_out = {diff[7], ov, (diff[7:0] == 8'h00), ~low_diff[4], ~diff[8]};
   assign bus.flags_we = bus.is_sub;
endmodule : swap_sub_alu
`default_nettype wire

// >>> rtl/swap_sub_exec.sv
// Execution datapath for the nibble-swap and subtract-with-borrow file-register instructions
//
// Behaviour
// - The swap writes the low nibble of the file register to the high nibble of the result and vice versa, flags unchanged.
// - The swap is recognised by its fixed six-bit opcode, then destination bit, bank bit and 8-bit file address.
// - Destination bit zero sends the result to the working register, one writes it back to the file register.
// - Bank bit zero selects the access bank, one lets the bank-select register pick the RAM bank.
// - With the extended set enabled, bank bit zero and address at most 95, indexed literal offset addressing is used.
// - Decode in the first quarter, read in the second, process in the third, write in the fourth; the file write strobe O_MEM_WR follows one clock later.
// - Subtract with borrow computes file minus working minus inverted carry and updates N, OV, C, DC and Z.
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module swap_sub_exec (
   input wire logic I_CLK,
   input wire logic I_SRST,
   input wire logic I_INSTR_VALID,
   input wire logic [15:0] I_INSTR,
   input wire logic I_EXT_SET_EN,
   input wire logic [3:0] I_BANK_SELECT_REG,
   input wire logic [11:0] I_INDEX_PTR,
   input wire logic [7:0] I_MEM_RDATA,
   output logic [11:0] O_MEM_ADDR,
   output logic O_MEM_RD,
   output logic O_MEM_WR,
   output logic [7:0] O_MEM_WDATA,
   output logic [7:0] O_WREG,
   output logic [4:0] O_FLAGS,
   output logic O_BUSY,
   output logic O_DONE
);
   // ==========================================================
   // Decode
   swap_sub_pkg::phase_e phase_reg, phase_next;
   logic [15:0] instr_reg;
   logic [7:0] fval_reg;
   logic [7:0] res_reg;
   logic [4:0] flagres_reg;
   logic flagwe_reg;
   logic [11:0] addr_reg;
   logic [7:0] wreg_reg;
   logic [4:0] flags_reg;
   logic mem_rd_reg, mem_wr_reg, busy_reg, done_reg;
   logic [7:0] wdata_reg;

   wire logic is_swap;
   wire logic is_subb;
   wire logic dest_file;
   wire logic bank_bit;
   wire logic [7:0] faddr;
   wire logic indexed;
   wire logic [11:0] eff_addr;
   wire logic start;
   wire logic in_read;
   wire logic in_proc;
   wire logic in_write;
   wire logic wr_fire;

   // Opcode match on the six upper bits of a word
   function automatic logic op_is(input logic [15:0] word, input logic [5:0] code);
      return word[swap_sub_pkg::OPC_HI:swap_sub_pkg::OPC_LO] == code;
   endfunction : op_is

   assign is_swap = op_is(I_INSTR, swap_sub_pkg::OPC_SWAP);
   assign is_subb = op_is(I_INSTR, swap_sub_pkg::OPC_SUBB);
   assign start = I_INSTR_VALID & (is_swap | is_subb) & (phase_reg == swap_sub_pkg::PH_DECODE);
   assign bank_bit = I_INSTR[swap_sub_pkg::BANK_BIT];
   assign faddr = I_INSTR[swap_sub_pkg::BANK_BIT-1:0];
   assign dest_file = instr_reg[swap_sub_pkg::DEST_BIT];
   assign indexed = I_EXT_SET_EN & ~bank_bit & (faddr <= swap_sub_pkg::INDEXED_MAX);
   // Access bank: low part of bank 0 and high part of the top bank
   assign eff_addr = indexed ? I_INDEX_PTR + {4'h0, faddr}
      : bank_bit ? {I_BANK_SELECT_REG, faddr}
      : (faddr < swap_sub_pkg::ACCESS_SPLIT) ? {4'h0, faddr} : {swap_sub_pkg::ACCESS_HIGH_BANK, faddr};

   // ==========================================================
   // Arithmetic unit
   alu_if alu_bus ();
   assign alu_bus.f_val = fval_reg;
   assign alu_bus.w_val = wreg_reg;
   assign alu_bus.carry_in = flags_reg[swap_sub_pkg::FLAG_C];
   assign alu_bus.is_sub = op_is(instr_reg, swap_sub_pkg::OPC_SUBB);

   swap_sub_alu u_alu (
      .bus(alu_bus)
   );

   // ==========================================================
   // Quarter-cycle sequencer, one instruction per four clocks
   always_comb begin
      phase_next = phase_reg;
      unique case (phase_reg)
         swap_sub_pkg::PH_DECODE: begin
            if (start) begin
               phase_next = swap_sub_pkg::PH_READ;
            end
         end
         swap_sub_pkg::PH_READ: phase_next = swap_sub_pkg::PH_PROC;
         swap_sub_pkg::PH_PROC: phase_next = swap_sub_pkg::PH_WRITE;
         swap_sub_pkg::PH_WRITE: phase_next = swap_sub_pkg::PH_DECODE;
      endcase
   end

   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         phase_reg <= swap_sub_pkg::PH_DECODE;
      end else begin
         phase_reg <= phase_next;
      end
   end

   // ==========================================================
   // Phase decode
   assign in_read = (phase_reg == swap_sub_pkg::PH_READ);
   assign in_proc = (phase_reg == swap_sub_pkg::PH_PROC);
   assign in_write = (phase_reg == swap_sub_pkg::PH_WRITE);
   assign wr_fire = in_write & dest_file;

   // Instruction and effective address are latched at acceptance
   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         instr_reg <= 16'h0000;
         addr_reg <= 12'h000;
      end else if (start) begin
         instr_reg <= I_INSTR;
         addr_reg <= eff_addr;
      end
   end

   // Read strobe stands for the read quarter only
   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         mem_rd_reg <= 1'b0;
      end else begin
         mem_rd_reg <= start;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         busy_reg <= 1'b0;
      end else if (start) begin
         busy_reg <= 1'b1;
      end else if (in_write) begin
         busy_reg <= 1'b0;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         fval_reg <= swap_sub_pkg::RESET_BYTE;
      end else if (in_read) begin
         fval_reg <= I_MEM_RDATA;
      end
   end

   // Result and flags are held until the write quarter
   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         res_reg <= swap_sub_pkg::RESET_BYTE;
         flagres_reg <= swap_sub_pkg::RESET_FLAGS;
         flagwe_reg <= 1'b0;
      end else if (in_proc) begin
         res_reg <= alu_bus.result;
         flagres_reg <= alu_bus.flags_out;
         flagwe_reg <= alu_bus.flags_we;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= in_write;
      end
   end

   // Write-back to the file register
   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         mem_wr_reg <= 1'b0;
         wdata_reg <= swap_sub_pkg::RESET_BYTE;
      end else begin
         mem_wr_reg <= wr_fire;
         if (wr_fire) begin
            wdata_reg <= res_reg;
         end
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         wreg_reg <= swap_sub_pkg::RESET_BYTE;
      end else if (in_write & ~dest_file) begin
         wreg_reg <= res_reg;
      end
   end

   // Swap leaves the flags alone
   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         flags_reg <= swap_sub_pkg::RESET_FLAGS;
      end else if (in_write & flagwe_reg) begin
         flags_reg <= flagres_reg;
      end
   end

   assign O_MEM_ADDR = addr_reg;
   assign O_MEM_RD = mem_rd_reg;
   assign O_MEM_WR = mem_wr_reg;
   assign O_MEM_WDATA = wdata_reg;
   assign O_WREG = wreg_reg;
   assign O_FLAGS = flags_reg;
   assign O_BUSY = busy_reg;
   assign O_DONE = done_reg;
endmodule : swap_sub_exec
`default_nettype wire

// >>> test/data_mem_model.sv
// Data memory model answering the datapath's file register reads and writes
`timescale 1ns/1ns
`default_nettype none
module data_mem_model (
   input wire logic clk,
   input wire logic [11:0] addr,
   input wire logic rd,
   input wire logic wr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [7:0] mem [4096];
   // Outside the read strobe the bus shows the inverse, never a stale copy
   assign rdata = rd ? mem[addr] : ~mem[addr];
   always @(posedge clk) if (wr) mem[addr] <= wdata;
endmodule : data_mem_model
`default_nettype wire

// >>> test/swap_sub_exec_assertions.sv
// Checker: timing, addressing and result relations at the datapath ports
`timescale 1ns/1ns
`default_nettype none
module swap_sub_exec_assertions (
   input wire logic I_CLK,
   input wire logic I_SRST,
   input wire logic I_INSTR_VALID,
   input wire logic [15:0] I_INSTR,
   input wire logic I_EXT_SET_EN,
   input wire logic [3:0] I_BANK_SELECT_REG,
   input wire logic [11:0] I_INDEX_PTR,
   input wire logic [7:0] I_MEM_RDATA,
   input wire logic [11:0] O_MEM_ADDR,
   input wire logic O_MEM_RD,
   input wire logic O_MEM_WR,
   input wire logic [7:0] O_MEM_WDATA,
   input wire logic [7:0] O_WREG,
   input wire logic [4:0] O_FLAGS,
   input wire logic O_BUSY,
   input wire logic O_DONE
);
   wire sw = I_INSTR[15:10] == swap_sub_pkg::OPC_SWAP;
   wire sb = I_INSTR[15:10] == swap_sub_pkg::OPC_SUBB;
   wire acc = I_INSTR_VALID && !O_BUSY && (sw || sb);
   wire dst = I_INSTR[9];
   wire bnk = I_INSTR[8];
   wire [7:0] fa = I_INSTR[7:0];
   logic [7:0] rd_q;
   always_ff @(posedge I_CLK) if (O_MEM_RD) rd_q <= I_MEM_RDATA;
   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_SRST);
   sequence swap_wb; acc && sw && dst ##1 O_MEM_RD; endsequence
   sequence sub_w; acc && sb && !dst ##1 O_MEM_RD; endsequence
   rd_follow_a: assert property (acc |=> O_MEM_RD && O_BUSY) else $error("no read");
   busy_span_a: assert property (acc |=> O_BUSY [*3] ##1 (!O_BUSY && O_DONE)) else $error("span");
   dest_sel_a: assert property (acc |-> ##4 O_MEM_WR == $past(dst, 4)) else $error("dest");
   bank_addr_a: assert property (acc && bnk |=> O_MEM_ADDR == {$past(I_BANK_SELECT_REG), $past(fa)}) else $error("bank");
   index_addr_a: assert property (acc && !bnk && I_EXT_SET_EN && fa <= 8'h5f
      |=> O_MEM_ADDR == $past(I_INDEX_PTR) + $past(fa)) else $error("index");
   swap_data_a: assert property (swap_wb |-> ##3 O_MEM_WR && O_MEM_WDATA == {rd_q[3:0], rd_q[7:4]}) else $error("swap");
   refuse_idle_a: assert property (!acc && !O_BUSY |=> !O_MEM_RD) else $error("refuse");
   sub_zero_a: assert property (sub_w |-> ##3 O_FLAGS[2] == (O_WREG == 8'h00)) else $error("zero");
endmodule : swap_sub_exec_assertions
bind swap_sub_exec swap_sub_exec_assertions chk_u (.*);
`default_nettype wire

// >>> test/swap_sub_exec_tb.sv
// Testbench: instruction scenarios against the datapath and a data memory model
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin miscompares++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module swap_sub_exec_tb;
   logic clk = 0, srst = 1, valid = 0, ext = 0, rd, wr, busy, done;
   logic [15:0] instr = 16'h0000;
   logic [3:0] bank_select_reg = 4'h0;
   logic [11:0] idx = 12'h000, addr;
   logic [7:0] rdata, wdata, wreg;
   logic [4:0] flags;
   int miscompares = 0, tests_run = 0, n_done = 0;
   swap_sub_exec dut_u (.I_CLK(clk), .I_SRST(srst), .I_INSTR_VALID(valid), .I_INSTR(instr), .I_EXT_SET_EN(ext),
      .I_BANK_SELECT_REG(bank_select_reg), .I_INDEX_PTR(idx), .I_MEM_RDATA(rdata), .O_MEM_ADDR(addr), .O_MEM_RD(rd),
      .O_MEM_WR(wr), .O_MEM_WDATA(wdata), .O_WREG(wreg), .O_FLAGS(flags), .O_BUSY(busy), .O_DONE(done));
   data_mem_model mem_u (.clk(clk), .addr(addr), .rd(rd), .wr(wr), .wdata(wdata), .rdata(rdata));
   initial forever #5 clk = ~clk;
   always @(negedge clk) if (done === 1'b1) n_done++;
   // ================ Shared tasks
   // Returns at the edge opening the done cycle, so a following call runs back to back
   task automatic issue(input logic [15:0] w);
      instr <= w;
      valid <= 1'b1;
      @(posedge clk);
      valid <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : issue
   task automatic final_report;
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : final_report
   // ================ Scenarios
   task automatic t_swap;
      bank_select_reg <= 4'h3;
      issue({6'h0e, 2'b00, 8'h10});
      issue({6'h0e, 2'b11, 8'h45});
      @(posedge clk);
      @(negedge clk);
      `CHK("wreg", 8'h0d, wreg)
      `CHK("mem345", 8'h35, mem_u.mem[12'h345])
      `CHK("flags", 5'h00, flags)
      @(posedge clk);
      $display("t_swap done");
   endtask : t_swap
   task automatic t_sub;
      bank_select_reg <= 4'h2;
      issue({6'h16, 2'b00, 8'h70});
      @(negedge clk);
      `CHK("wreg", 8'h0b, wreg)
      `CHK("flags", 5'h01, flags)
      @(posedge clk);
      issue({6'h16, 2'b11, 8'h22});
      @(posedge clk);
      @(negedge clk);
      `CHK("mem222", 8'h00, mem_u.mem[12'h222])
      `CHK("flags", 5'h07, flags)
      @(posedge clk);
      $display("t_sub done");
   endtask : t_sub
   task automatic t_index;
      ext <= 1'b1;
      idx <= 12'h300;
      issue({6'h0e, 2'b10, 8'h05});
      issue({6'h0e, 2'b10, 8'h60});
      @(posedge clk);
      @(negedge clk);
      `CHK("wdata", 8'h5a, wdata)
      `CHK("mem305", 8'h35, mem_u.mem[12'h305])
      `CHK("memf60", 8'h5a, mem_u.mem[12'hf60])
      `CHK("flags", 5'h07, flags)
      @(posedge clk);
      $display("t_index done");
   endtask : t_index
   task automatic t_refuse;
      instr <= 16'hfc45;
      valid <= 1'b1;
      @(posedge clk);
      valid <= 1'b0;
      repeat (5) @(posedge clk);
      #1;
      `CHK("busy", 1'b0, busy)
      `CHK("ndone", 6, n_done)
      $display("t_refuse done");
   endtask : t_refuse
   initial begin
      mem_u.mem[12'h010] = 8'hd0;
      mem_u.mem[12'h345] = 8'h53;
      mem_u.mem[12'hf70] = 8'h19;
      mem_u.mem[12'h222] = 8'h0b;
      mem_u.mem[12'h305] = 8'h53;
      mem_u.mem[12'hf60] = 8'ha5;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_swap;
      t_sub;
      t_index;
      t_refuse;
      final_report;
   end
   initial begin
      #2000;
      miscompares++;
      final_report;
   end
endmodule : swap_sub_exec_tb
`default_nettype wire
